// File: logic/adcd_cfg.svh
// register offsets, field positions and reset values for the diagnostic
// configuration block; assumes word-per-register AHB-Lite mapping
`ifndef ADCD_CFG_SVH
`define ADCD_CFG_SVH
// =========================================================
// register indices (byte address is four times the index)
`define ADCD_IDX_RESULT 8'h50
`define ADCD_IDX_CONFIG 8'h51
`define ADCD_IDX_CELLEN 8'h52
`define ADCD_IDX_OFA 8'h57
`define ADCD_IDX_OFB 8'h58
`define ADCD_IDX_EFA 8'h59
`define ADCD_IDX_EFB 8'h5a
`define ADCD_IDX_CTRL 8'h60
// =========================================================
// field masks and reset values
`define ADCD_CONFIG_MASK 16'hfbdf
`define ADCD_CELLEN_MASK 16'h1fff
`define ADCD_WORD_MASK 16'h0fff
`define ADCD_CTRL_MASK 16'h0003
`define ADCD_RST_CONFIG 16'h0000
`define ADCD_RST_CELLEN 16'h0000
`define ADCD_RST_WORD 16'h0000
`define ADCD_RST_RESULT 16'h0000
// =========================================================
// diagnostic selector codes
`define ADCD_SEL_NONE0 3'h0
`define ADCD_SEL_ALTERNATE_REFERENCE 3'h1
`define ADCD_SEL_SUPPLY 3'h2
`define ADCD_SEL_LSOFS 3'h3
`define ADCD_SEL_ZERO 3'h4
`define ADCD_SEL_FULL 3'h5
`define ADCD_SEL_TEMP 3'h6
`define ADCD_SEL_NONE7 3'h7
`define ADCD_ZERO_CODE 14'h0000
`define ADCD_FULL_CODE 14'h3fff
`endif

// File: logic/adcd_pkg.sv
// types shared by the diagnostic configuration block
// assumes adcd_cfg.svh holds all numbers
package adcd_pkg;
    // =========================================================
    // diagnostic configuration word layout
    typedef struct packed {
        logic [3:0] test_current_level;
        logic test_current_direction;
        logic rsvd10;
        logic [1:0] aux_input_test_enable;
        logic mux_output_select;
        logic mux_pair_routing;
        logic rsvd5;
        logic mux_test_current_enable;
        logic alternate_path_select;
        logic [2:0] diagnostic_selector;
    } adcd_config_t;
    // analog control bundle toward the front end
    typedef struct packed {
        logic [3:0] test_current_level;
        logic test_current_direction;
        logic [12:0] cell_source_enable;
        logic [12:0] cell_source_dir;
        logic [1:0] aux_source_enable;
        logic mux_source_even;
        logic mux_source_odd;
        logic alternate_path_select;
        logic [2:0] diagnostic_selector;
    } adcd_analog_t;
    // diagnostic measurement kinds
    typedef enum logic [6:0] {
        ADCD_MEAS_NONE = 7'h01,
        ADCD_MEAS_ALTERNATE_REFERENCE = 7'h02,
        ADCD_MEAS_SUPPLY = 7'h04,
        ADCD_MEAS_LSOFS = 7'h08,
        ADCD_MEAS_ZERO = 7'h10,
        ADCD_MEAS_FULL = 7'h20,
        ADCD_MEAS_TEMP = 7'h40
    } adcd_meas_t;
endpackage : adcd_pkg

// File: logic/adcd_top.sv
// diagnostic configuration, test-word and result registers of the
// cell-measurement converter, reached over AHB-Lite; assumes the
// converter core supplies cycle-start, conversion and result strobes
// on i_sys_clk
// the bus slave never stretches a transfer: hreadyout stays high and
// every response is okay, so a master needs no wait-state handling
//
// Operation
// [R1] result holds 14 bits at 15:2, read-only
// [R2] level code sets current (code+1) times step
// [R3] direction bit sources or sinks; lowest cell sources
// [R4] aux enables connect sources to aux inputs
// [R5] output select picks even or odd output
// [R6] pair bit zero drives both outputs
// [R7] mux enable switches mux test sources on
// [R8] mux enable sampled at cycle start only
// [R9] alternate path takes cells from switch inputs
// [R10] selector picks diagnostic measurement kind
// [R11] codes four and five force zero, full scale
// [R12] cell enables connect sources per cell input
// [R13] odd first word replaces first conversion data
// [R14] odd second word feeds second conversion
// [R15] even first word in oversampling mode
// [R16] even second word in oversampling mode
// [R17] reserved bits read zero; result updates on done; here only for selector codes 1 to 6
//
// Register access over AHB-Lite is this design's own decision.
`include "adcd_cfg.svh"
module adcd_top
    import adcd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_cycle_start,
    input wire logic i_conv_valid,
    input wire logic i_conv_second,
    input wire logic i_sample_odd,
    input wire logic [11:0] i_conv_data,
    input wire logic i_diagnostic_result_done,
    input wire logic [13:0] i_diagnostic_result_code,
    output adcd_analog_t o_analog,
    output logic [11:0] o_alu_data,
    output logic o_alu_valid,
    output adcd_meas_t o_meas_kind
);
    // =========================================================
    // register storage
    // words are sixteen bits wide, ctrl_reg only two; the upper half of the bus word
    // is dropped on writes and returned as zero on reads
    logic [15:0] config_reg; // diagnostic_config
    logic [15:0] cellen_reg; // cell_test_current_enable
    logic [15:0] ofa_reg; // alu_test_word_odd_first
    logic [15:0] ofb_reg; // alu_test_word_odd_second
    logic [15:0] efa_reg; // alu_test_word_even_first
    logic [15:0] efb_reg; // alu_test_word_even_second
    logic [15:0] result_reg; // diagnostic_result
    logic [1:0] ctrl_reg; // bit0 self-test active, bit1 oversampling
    logic mux_en_reg; // mux enable latched at cycle start
    adcd_config_t cfg; // field view of the config word

    // the struct cast only renames bits, it adds no logic
    assign cfg = adcd_config_t'(config_reg);

    // =========================================================
    // ahb-lite slave: address phase capture
    logic wr_pend_reg; // a write data phase is due
    logic [7:0] wr_idx_reg; // word index of the pending write
    logic addr_ok; // valid single-word transfer this cycle
    logic [7:0] a_idx; // word index of the address phase

    // only htrans bit one is looked at: nonseq and seq both start a
    // transfer, idle and busy never do; hsize is ignored since every
    // access is a whole word
    assign addr_ok = i_hsel && i_hready && i_htrans[1];
    // address bits above nine are not decoded, so the map repeats
    // every kilobyte of the slave's range
    assign a_idx = i_haddr[9:2];

    // latch write address; data follows in the next cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end else begin
            // a write address phase arms exactly one data phase
            wr_pend_reg <= addr_ok && i_hwrite;
            // the index is kept for reads too; only the flag matters
            if (addr_ok) begin
                wr_idx_reg <= a_idx;
            end
        end
    end

    // zero wait states and always okay, so these stay constant
    // registered rather than tied so that every top output leaves a flop
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // =========================================================
    // register writes; masks drop reserved bits at the write
    logic [15:0] wdata; // low half of the write data

    // hwdata is only valid in the data phase, one clock after the address
    assign wdata = i_hwdata[15:0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            config_reg <= `ADCD_RST_CONFIG;
            cellen_reg <= `ADCD_RST_CELLEN;
            ofa_reg <= `ADCD_RST_WORD;
            ofb_reg <= `ADCD_RST_WORD;
            efa_reg <= `ADCD_RST_WORD;
            efb_reg <= `ADCD_RST_WORD;
            // self-test off after reset so converter data reaches the alu
            ctrl_reg <= 2'h0;
        end else if (wr_pend_reg) begin
            // the write lands at the data phase edge
            unique case (wr_idx_reg)
                // reserved bits ten and five are cleared on the way in
                `ADCD_IDX_CONFIG: begin
                    config_reg <= wdata & `ADCD_CONFIG_MASK; // R17
                end
                // cell enables use the low thirteen bits only
                `ADCD_IDX_CELLEN: begin
                    cellen_reg <= wdata & `ADCD_CELLEN_MASK; // R17
                end
                // test words keep twelve bits; the top nibble reads zero
                `ADCD_IDX_OFA: begin
                    ofa_reg <= wdata & `ADCD_WORD_MASK; // R17
                end
                `ADCD_IDX_OFB: begin
                    ofb_reg <= wdata & `ADCD_WORD_MASK;
                end
                `ADCD_IDX_EFA: begin
                    efa_reg <= wdata & `ADCD_WORD_MASK;
                end
                `ADCD_IDX_EFB: begin
                    efb_reg <= wdata & `ADCD_WORD_MASK;
                end
                // local control: bit zero self-test, bit one oversampling
                `ADCD_IDX_CTRL: begin
                    ctrl_reg <= wdata[1:0];
                end
                // result register and unmapped words ignore writes
                default: begin
                end
            endcase
        end
    end

    // =========================================================
    // read data, registered in the address phase
    logic [15:0] rd_mux; // selected register value

    // decode uses the live address phase so the data is ready one clock
    // later, in the data phase, with no wait state

    always_comb begin
        rd_mux = 16'h0000;
        unique case (a_idx)
            // the result word already has its two low bits cleared
            `ADCD_IDX_RESULT: rd_mux = result_reg; // R1
            `ADCD_IDX_CONFIG: rd_mux = config_reg;
            `ADCD_IDX_CELLEN: rd_mux = cellen_reg;
            `ADCD_IDX_OFA: rd_mux = ofa_reg;
            `ADCD_IDX_OFB: rd_mux = ofb_reg;
            `ADCD_IDX_EFA: rd_mux = efa_reg;
            `ADCD_IDX_EFB: rd_mux = efb_reg;
            `ADCD_IDX_CTRL: rd_mux = {14'h0000, ctrl_reg};
            // unmapped words read as zero
            default: rd_mux = 16'h0000;
        endcase
    end

    // a read issued right after a write to the same word sees the old
    // value; masters needing the new one must leave one idle cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_ok && !i_hwrite) begin
            // held between reads so a slow master may sample late
            o_hrdata <= {16'h0000, rd_mux};
        end
    end

    // =========================================================
    // the routing bits are not latched; only the enable waits for a
    // cycle start, so a route change mid-cycle moves the current at once
    // mux enable takes effect only at a measurement cycle start
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            // sources stay off until the first cycle start after reset
            mux_en_reg <= 1'b0;
        end else if (i_cycle_start) begin
            mux_en_reg <= cfg.mux_test_current_enable; // R8
        end
    end

    // =========================================================
    // analog controls; the level code passes unchanged, the analog
    // dac makes (code+1) steps of the step size chosen elsewhere
    logic [12:0] cell_dir; // per-cell direction, one means source

    // cell zero has nothing below it to sink into, so it always sources
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++) begin : g_cell
            if (gi == 0) begin : g_low
                assign cell_dir[gi] = 1'b1; // R3
            end else begin : g_up
                assign cell_dir[gi] = cfg.test_current_direction; // R3
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            // all sources off and the main path selected in reset
            o_analog <= '0;
        end else begin
            o_analog.test_current_level <= cfg.test_current_level; // R2
            o_analog.test_current_direction <= cfg.test_current_direction;
            o_analog.cell_source_enable <= cellen_reg[12:0]; // R12
            o_analog.cell_source_dir <= cell_dir; // R3
            o_analog.aux_source_enable <= cfg.aux_input_test_enable; // R4
            // pair bit low feeds both outputs, high picks one
            o_analog.mux_source_even <= mux_en_reg
                && (!cfg.mux_pair_routing
                    || !cfg.mux_output_select); // R5 R6 R7
            o_analog.mux_source_odd <= mux_en_reg
                && (!cfg.mux_pair_routing
                    || cfg.mux_output_select); // R5 R6 R7
            // switch inputs replace cell inputs while this bit is set
            o_analog.alternate_path_select <= cfg.alternate_path_select; // R9
            o_analog.diagnostic_selector <= cfg.diagnostic_selector;
        end
    end

    // =========================================================
    // measurement kind decode from the selector
    // the selector is fully decoded; both idle codes map to none
    adcd_meas_t meas_next; // decoded kind

    always_comb begin
        meas_next = ADCD_MEAS_NONE;
        unique case (cfg.diagnostic_selector)
            `ADCD_SEL_ALTERNATE_REFERENCE: meas_next = ADCD_MEAS_ALTERNATE_REFERENCE; // R10
            `ADCD_SEL_SUPPLY: meas_next = ADCD_MEAS_SUPPLY;
            `ADCD_SEL_LSOFS: meas_next = ADCD_MEAS_LSOFS;
            `ADCD_SEL_ZERO: meas_next = ADCD_MEAS_ZERO; // R11
            `ADCD_SEL_FULL: meas_next = ADCD_MEAS_FULL; // R11
            `ADCD_SEL_TEMP: meas_next = ADCD_MEAS_TEMP;
            `ADCD_SEL_NONE0: meas_next = ADCD_MEAS_NONE; // R10
            `ADCD_SEL_NONE7: meas_next = ADCD_MEAS_NONE; // R10
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_meas_kind <= ADCD_MEAS_NONE;
        end else begin
            // kind follows the selector one clock late, like o_analog
            o_meas_kind <= meas_next;
        end
    end

    // =========================================================
    // result capture: only on a completed diagnostic conversion; the
    // forced codes replace the converter word so the path is checked
    // a done pulse under an idle selector is dropped, so the last
    // result survives an unrelated conversion
    logic [13:0] res_code; // code to be stored

    always_comb begin
        // default is the converter's own word
        res_code = i_diagnostic_result_code;
        if (meas_next == ADCD_MEAS_ZERO) begin
            res_code = `ADCD_ZERO_CODE; // R11
        end else if (meas_next == ADCD_MEAS_FULL) begin
            res_code = `ADCD_FULL_CODE; // R11
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            result_reg <= `ADCD_RST_RESULT;
        end else if (i_diagnostic_result_done && meas_next != ADCD_MEAS_NONE) begin
            result_reg <= {res_code, 2'b00}; // R1 R17
        end
    end

    // =========================================================
    // alu feed: self-test words replace converter data
    logic [11:0] alu_next; // word chosen for this conversion
    logic self_test; // self-test active
    logic oversample; // oversampling mode

    // odd samples take test words whenever self-test is on; even ones
    // only in oversampling mode, else the converter word passes
    assign self_test = ctrl_reg[0];
    assign oversample = ctrl_reg[1];

    // even samples use test words only while oversampling
    always_comb begin
        // normal operation: the converter word passes untouched
        alu_next = i_conv_data;
        if (self_test && i_sample_odd && !i_conv_second) begin
            alu_next = ofa_reg[11:0]; // R13
        end else if (self_test && i_sample_odd) begin
            alu_next = ofb_reg[11:0]; // R14
        end else if (self_test && oversample && !i_conv_second) begin
            alu_next = efa_reg[11:0]; // R15
        end else if (self_test && oversample) begin
            alu_next = efb_reg[11:0]; // R16
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_alu_data <= 12'h000;
            o_alu_valid <= 1'b0;
        end else begin
            // data is held between strobes so downstream may sample late
            o_alu_valid <= i_conv_valid;
            if (i_conv_valid) begin
                o_alu_data <= alu_next;
            end
        end
    end
endmodule : adcd_top

// File: verif/adcd_top_asserts.sv
// concurrent checks on the diagnostic configuration block's ports
// assumes it is bound to adcd_top and sees only that module's ports
module adcd_top_asserts
    import adcd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic i_cycle_start,
    input wire logic i_conv_valid,
    input wire logic i_diagnostic_result_done,
    input wire logic [31:0] o_hrdata,
    input wire logic o_alu_valid,
    input wire adcd_analog_t o_analog,
    input wire adcd_meas_t o_meas_kind
);
    // =========================================================
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    // registers are at most 16 bits, so the upper half never carries data
    upper_zero_a: assert property (o_hrdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    // a result read returns its two low bits cleared
    result_lsb_a: assert property (i_hsel && i_hready && i_htrans[1]
        && !i_hwrite && i_haddr == 32'h0000_0140 |=> o_hrdata[1:0] == 2'b00)
        else $error("result low bits not zero");
    // alu strobe trails the converter strobe by exactly one clock
    alu_valid_a: assert property ($past(i_nrst) |->
        o_alu_valid == $past(i_conv_valid))
        else $error("alu strobe not one clock after converter strobe");
    // exactly one measurement kind at a time
    kind_onehot_a: assert property ($onehot(o_meas_kind))
        else $error("measurement kind not one-hot");
    // the two idle selector codes measure nothing
    kind_none_a: assert property (o_analog.diagnostic_selector
        inside {3'h0, 3'h7} |-> o_meas_kind == ADCD_MEAS_NONE)
        else $error("idle selector gave a measurement");
    // forced codes select the zero and full scale kinds
    kind_forced_a: assert property (o_analog.diagnostic_selector == 3'h4
        |-> o_meas_kind == ADCD_MEAS_ZERO)
        else $error("zero scale code not honoured");
    kind_full_a: assert property (o_analog.diagnostic_selector == 3'h5
        |-> o_meas_kind == ADCD_MEAS_FULL)
        else $error("full scale code not honoured");
    // lowest cell input always sources, whatever the direction bit
    lowest_src_a: assert property ($past(i_nrst)
        |-> o_analog.cell_source_dir[0])
        else $error("lowest cell input not sourcing");
    // mux sources switch on or off only after a cycle start
    mux_latch_a: assert property (!$stable(o_analog.mux_source_even
        || o_analog.mux_source_odd) |-> $past(i_cycle_start)
        || $past(i_cycle_start, 2))
        else $error("mux source changed without cycle start");
    cover property (i_diagnostic_result_done);
    cover property (o_alu_valid);
    cover property ($rose(o_analog.mux_source_odd));
endmodule : adcd_top_asserts

bind adcd_top adcd_top_asserts chk (.i_sys_clk, .i_nrst, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_cycle_start,
    .i_conv_valid, .i_diagnostic_result_done, .o_hrdata, .o_alu_valid, .o_analog,
    .o_meas_kind);

// File: verif/tb_adcd_top.sv
// self-checking bench for the diagnostic configuration block
// assumes the bound checker and a single 100 MHz clock
`include "adcd_cfg.svh"
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module tb_adcd_top
    import adcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] cfg = `ADCD_IDX_CONFIG;
    logic clk, nrst, hwrite, hready, hresp, cyc, cv, csec, sodd, done, aluv;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, mux;
    logic [11:0] cdata, alud;
    logic [13:0] dcode;
    adcd_analog_t an;
    adcd_meas_t kind;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    assign mux = {an.mux_source_even, an.mux_source_odd};
    adcd_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_cycle_start(cyc), .i_conv_valid(cv), .i_conv_second(csec),
        .i_sample_odd(sodd), .i_conv_data(cdata), .i_diagnostic_result_done(done),
        .i_diagnostic_result_code(dcode), .o_analog(an), .o_alu_data(alud),
        .o_alu_valid(aluv), .o_meas_kind(kind));
    // =========================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // =========================================================
    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [31:0] wd);
        @(posedge clk);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        `CHK(rd, e)
        `CHK({hready, hresp}, 2'b10)
    endtask : rchk
    // registered outputs trail the register by one clock
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic pulse_cycle();
        @(posedge clk);
        cyc <= 1'b1;
        @(posedge clk);
        cyc <= 1'b0;
        settle();
    endtask : pulse_cycle
    // one converter word with the given sample parity and half
    task automatic conv(input logic odd, input logic sec,
        input logic [11:0] e);
        @(posedge clk);
        cv <= 1'b1;
        sodd <= odd;
        csec <= sec;
        cdata <= 12'h5a5;
        @(posedge clk);
        cv <= 1'b0;
        #1;
        `CHK(aluv, 1'b1)
        `CHK(alud, e)
    endtask : conv
    // =========================================================
    // scenarios
    // cleared after reset; an unmapped place reads zero
    task automatic t_reset();
        rchk(cfg, 32'h0);
        rchk(`ADCD_IDX_CELLEN, 32'h0);
        rchk(`ADCD_IDX_EFA, 32'h0);
        rchk(`ADCD_IDX_EFB, 32'h0);
        rchk(`ADCD_IDX_RESULT, 32'h0);
        rchk(8'h53, 32'h0);
        rchk(`ADCD_IDX_CTRL, 32'h0);
    endtask : t_reset
    // all ones written: reserved bits drop, result ignores the write
    task automatic t_fields();
        bus(1'b1, cfg, 32'hffff_ffff);
        bus(1'b1, `ADCD_IDX_CELLEN, 32'hffff_ffff);
        bus(1'b1, `ADCD_IDX_RESULT, 32'hffff_ffff);
        rchk(cfg, 32'h0000_fbdf);
        rchk(`ADCD_IDX_CELLEN, 32'h0000_1fff);
        rchk(`ADCD_IDX_RESULT, 32'h0);
        `CHK(an.test_current_level, 4'hf)
        `CHK(an.test_current_direction, 1'b1)
        `CHK(an.cell_source_enable, 13'h1fff)
        `CHK(an.cell_source_dir, 13'h1fff)
        `CHK(an.aux_source_enable, 2'h3)
        `CHK(an.alternate_path_select, 1'b1)
        `CHK(mux, 2'b00)
        bus(1'b1, cfg, 32'h0);
        settle();
        `CHK(an.cell_source_dir, 13'h0001)
        `CHK(an.test_current_direction, 1'b0)
        `CHK(an.alternate_path_select, 1'b0)
    endtask : t_fields
    // mux enable only lands at a cycle start; pair and select route it
    task automatic t_mux();
        pulse_cycle();
        bus(1'b1, cfg, 32'h0000_0010);
        settle();
        `CHK(mux, 2'b00)
        pulse_cycle();
        `CHK(mux, 2'b11)
        bus(1'b1, cfg, 32'h0000_0050);
        settle();
        `CHK(mux, 2'b10)
        bus(1'b1, cfg, 32'h0000_00d0);
        settle();
        `CHK(mux, 2'b01)
        bus(1'b1, cfg, 32'h0000_00c0);
        settle();
        `CHK(mux, 2'b01)
        pulse_cycle();
        `CHK(mux, 2'b00)
    endtask : t_mux
    // every selector code, with a completed conversion after each
    task automatic t_diagnostic_result();
        adcd_meas_t kinds [8] = '{ADCD_MEAS_NONE, ADCD_MEAS_ALTERNATE_REFERENCE,
            ADCD_MEAS_SUPPLY, ADCD_MEAS_LSOFS, ADCD_MEAS_ZERO,
            ADCD_MEAS_FULL, ADCD_MEAS_TEMP, ADCD_MEAS_NONE};
        logic [15:0] res;
        logic [13:0] code;
        res = 16'h0000;
        for (int s = 0; s < 8; s++) begin
            code = 14'h1000 + 14'(s * 14'h111);
            bus(1'b1, cfg, {29'h0, 3'(s)});
            settle();
            `CHK(kind, kinds[s])
            `CHK(an.diagnostic_selector, 3'(s))
            @(posedge clk);
            done <= 1'b1;
            dcode <= code;
            @(posedge clk);
            done <= 1'b0;
            if (s == 4) res = 16'h0000;
            else if (s == 5) res = 16'hfffc;
            else if (s != 0 && s != 7) res = {code, 2'b00};
            rchk(`ADCD_IDX_RESULT, {16'h0, res});
        end
    endtask : t_diagnostic_result
    // self-test words replace converter data by parity and half
    task automatic t_alu();
        bus(1'b1, `ADCD_IDX_OFA, 32'hffff_fabc);
        bus(1'b1, `ADCD_IDX_OFB, 32'h0000_0123);
        bus(1'b1, `ADCD_IDX_EFA, 32'h0000_0456);
        bus(1'b1, `ADCD_IDX_EFB, 32'h0000_0789);
        rchk(`ADCD_IDX_OFA, 32'h0000_0abc);
        conv(1'b1, 1'b0, 12'h5a5);
        bus(1'b1, `ADCD_IDX_CTRL, 32'h0000_0001);
        conv(1'b1, 1'b0, 12'habc);
        conv(1'b1, 1'b1, 12'h123);
        conv(1'b0, 1'b0, 12'h5a5);
        bus(1'b1, `ADCD_IDX_CTRL, 32'h0000_0003);
        rchk(`ADCD_IDX_CTRL, 32'h0000_0003);
        conv(1'b0, 1'b0, 12'h456);
        conv(1'b0, 1'b1, 12'h789);
    endtask : t_alu
    // =========================================================
    // main sequence, with a second reset in mid-run
    initial begin
        nrst = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        {cyc, cv, csec, sodd, done} = 5'h00;
        cdata = 12'h000;
        dcode = 14'h0000;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_fields();
        t_mux();
        t_diagnostic_result();
        t_alu();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        print_verdict();
    end
endmodule : tb_adcd_top
